// ===== pkg/mpcp_consts.svh
// Offsets, field positions, reset values and counts of the main clock path.
`ifndef MPCP_CONSTS_SVH
`define MPCP_CONSTS_SVH
`define MPCP_ADDR_W 8
`define MPCP_DATA_W 32
`define MPCP_ADDR_FACTOR 8'h00
`define MPCP_ADDR_DIVSEL 8'h04
`define MPCP_ADDR_STATUS 8'h08
`define MPCP_INT_LSB 0
`define MPCP_INT_W 7
`define MPCP_FRAC_LSB 8
`define MPCP_FRAC_W_DEF 8
`define MPCP_DIV_W 6
`define MPCP_INT_RST 7'h00
`define MPCP_DIV_RST 6'h00
`define MPCP_INT_BYPASS 7'h00
`define MPCP_DIV_PASS 6'h00
`define MPCP_HALF_EDGES 6'h01
`define MPCP_ST_BYPASS 0
`define MPCP_ST_MUX 1
`define MPCP_ST_SYS 2
`endif

// ===== pkg/mpcp_pkg.sv
// Types shared by the main clock path modules.
`default_nettype none
`include "mpcp_consts.svh"
package mpcp_pkg;
  typedef logic [`MPCP_INT_W-1:0] mpcp_int_t;
  typedef logic [`MPCP_DIV_W-1:0] mpcp_div_t;
  typedef logic [`MPCP_ADDR_W-1:0] mpcp_addr_t;
  typedef logic [`MPCP_DATA_W-1:0] mpcp_data_t;
endpackage : mpcp_pkg
`default_nettype wire

// ===== hw/mpcp_edge_div.sv
// Divider that toggles its output after a set number of input rising edges.
`timescale 1ns/1ns
`default_nettype none
`include "mpcp_consts.svh"
module mpcp_edge_div (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_level,
  input wire mpcp_pkg::mpcp_div_t i_half,
  output var logic o_clk
);
  logic prev_q;
  logic prev_d;
  logic out_q;
  logic out_d;
  mpcp_pkg::mpcp_div_t cnt_q;
  mpcp_pkg::mpcp_div_t cnt_d;

  // A zero half period holds the output, so a bad setting cannot race.
  always_comb begin
    prev_d = i_level;
    out_d = out_q;
    cnt_d = cnt_q;
    if (i_level && !prev_q && (i_half != `MPCP_DIV_PASS)) begin
      if (cnt_q + 6'h01 >= i_half) begin
        cnt_d = `MPCP_DIV_PASS;
        out_d = !out_q;
      end else begin
        cnt_d = cnt_q + 6'h01;
      end
    end
  end

  // Registers of the edge detector and the toggle.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_q <= 1'b0;
      out_q <= 1'b0;
      cnt_q <= `MPCP_DIV_PASS;
    end else begin
      prev_q <= prev_d;
      out_q <= out_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_clk = out_q;
endmodule : mpcp_edge_div
`default_nettype wire

// ===== hw/mpcp_top.sv
// Main clock path: factor registers, halver, bypass mux and system divider.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "mpcp_consts.svh"
// Operation
// R1: PLL reference comes only from primary pin.
// R2: Auxiliary pin feeds only USB and CAN.
// R3: PLL multiplies by integer plus fractional factor.
// R4: Software keeps PLL output 110 to 550 MHz.
// R5: PLL output halved before the mux.
// R6: Mux picks halved PLL or oscillator reference.
// R7: Integer factor zero selects bypass.
// R8: Divider after mux makes the system clock.
// R9: Integer field bits 6:0, zero is bypass.
// R10: Fraction width and step are parameters.
module mpcp_top #(
  parameter int FRAC_W = `MPCP_FRAC_W_DEF
) (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire mpcp_pkg::mpcp_addr_t I_ADDR,
  input wire mpcp_pkg::mpcp_data_t I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_PRIMARY_CLOCK_PIN,
  input wire logic I_AUX_CLOCK_PIN,
  input wire logic I_PLL_OUT,
  output var mpcp_pkg::mpcp_data_t O_RDATA,
  output var mpcp_pkg::mpcp_int_t O_PLL_INT_FACTOR,
  output var logic [FRAC_W-1:0] O_PLL_FRAC_FACTOR,
  output var logic O_PLL_REF_CLK,
  output var logic O_AUX_CLK_USB,
  output var logic O_AUX_CLK_CAN,
  output var logic O_BYPASS,
  output var logic O_SYS_CLK
);
  mpcp_pkg::mpcp_int_t int_q;
  mpcp_pkg::mpcp_int_t int_d;
  logic [FRAC_W-1:0] frac_q;
  logic [FRAC_W-1:0] frac_d;
  mpcp_pkg::mpcp_div_t div_q;
  mpcp_pkg::mpcp_div_t div_d;
  mpcp_pkg::mpcp_data_t rdata_q;
  mpcp_pkg::mpcp_data_t rdata_d;
  logic ref_q;
  logic aux_q;
  logic mux_q;
  logic mux_d;
  logic sys_q;
  logic sys_d;
  logic bypass_q;
  logic bypass_d;
  logic half_clk;
  logic sys_div_clk;

  // Register writes; the fraction step is one part in two to the FRAC_W.
  always_comb begin
    int_d = int_q;
    frac_d = frac_q;
    div_d = div_q;
    if (I_WR && I_ADDR == `MPCP_ADDR_FACTOR) begin
      int_d = I_WDATA[`MPCP_INT_LSB +: `MPCP_INT_W]; // [R9]
      frac_d = I_WDATA[`MPCP_FRAC_LSB +: FRAC_W]; // [R10]
    end
    if (I_WR && I_ADDR == `MPCP_ADDR_DIVSEL) begin
      div_d = I_WDATA[`MPCP_DIV_W-1:0];
    end
  end

  // Read data stand only in the cycle after the strobe, else zero.
  always_comb begin
    rdata_d = '0;
    if (I_RD) begin
      case (I_ADDR)
        `MPCP_ADDR_FACTOR: begin
          rdata_d[`MPCP_INT_LSB +: `MPCP_INT_W] = int_q;
          rdata_d[`MPCP_FRAC_LSB +: FRAC_W] = frac_q;
        end
        `MPCP_ADDR_DIVSEL: begin
          rdata_d[`MPCP_DIV_W-1:0] = div_q;
        end
        `MPCP_ADDR_STATUS: begin
          rdata_d[`MPCP_ST_BYPASS] = bypass_q;
          rdata_d[`MPCP_ST_MUX] = mux_q;
          rdata_d[`MPCP_ST_SYS] = sys_q;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  // Register block state.
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      int_q <= `MPCP_INT_RST;
      frac_q <= '0;
      div_q <= `MPCP_DIV_RST;
      rdata_q <= '0;
    end else begin
      int_q <= int_d;
      frac_q <= frac_d;
      div_q <= div_d;
      rdata_q <= rdata_d;
    end
  end

  // The PLL output is halved by toggling on each of its rising edges.
  mpcp_edge_div u_half (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_level(I_PLL_OUT),
    .i_half(`MPCP_HALF_EDGES), // [R5]
    .o_clk(half_clk)
  );

  // The system divider divides by twice the select, or passes at zero.
  mpcp_edge_div u_sysdiv (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_level(mux_q),
    .i_half(div_q), // [R8]
    .o_clk(sys_div_clk)
  );

  // Bypass mux and output selection; the aux pin never enters the mux.
  always_comb begin
    bypass_d = (int_q == `MPCP_INT_BYPASS); // [R7]
    mux_d = bypass_d ? ref_q : half_clk; // [R6]
    sys_d = (div_q == `MPCP_DIV_PASS) ? mux_q : sys_div_clk; // [R8]
  end

  // Clock path registers; every clock output and O_BYPASS come from one of these.
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ref_q <= 1'b0;
      aux_q <= 1'b0;
      mux_q <= 1'b0;
      sys_q <= 1'b0;
      bypass_q <= 1'b1;
    end else begin
      ref_q <= I_PRIMARY_CLOCK_PIN; // [R1]
      aux_q <= I_AUX_CLOCK_PIN; // [R2]
      mux_q <= mux_d;
      sys_q <= sys_d;
      bypass_q <= bypass_d;
    end
  end

  // Factor fields drive the analog PLL directly.
  assign O_PLL_INT_FACTOR = int_q; // [R3]
  assign O_PLL_FRAC_FACTOR = frac_q; // [R3]
  assign O_PLL_REF_CLK = ref_q;
  assign O_AUX_CLK_USB = aux_q;
  assign O_AUX_CLK_CAN = aux_q;
  assign O_BYPASS = bypass_q;
  assign O_SYS_CLK = sys_q;
  assign O_RDATA = rdata_q;

  // Checks tie each stage to its cause.
  a_ref_from_primary: assert property ( // [R1]
    @(posedge I_CLK) disable iff (!I_RST_B)
    ##1 O_PLL_REF_CLK == $past(I_PRIMARY_CLOCK_PIN))
    else $error("PLL reference does not follow primary pin");
  a_aux_only_periph: assert property ( // [R2]
    @(posedge I_CLK) disable iff (!I_RST_B)
    ##1 (O_AUX_CLK_USB == $past(I_AUX_CLOCK_PIN)) &&
    (O_AUX_CLK_CAN == $past(I_AUX_CLOCK_PIN)))
    else $error("Aux clock outputs do not follow aux pin");
  a_factor_write_lands: assert property ( // [R9]
    @(posedge I_CLK) disable iff (!I_RST_B)
    (I_WR && I_ADDR == `MPCP_ADDR_FACTOR) |=>
    O_PLL_INT_FACTOR == $past(I_WDATA[6:0]) &&
    O_PLL_FRAC_FACTOR == $past(I_WDATA[`MPCP_FRAC_LSB +: FRAC_W]))
    else $error("Factor write did not reach PLL outputs");
  a_half_on_rise: assert property ( // [R5]
    @(posedge I_CLK) disable iff (!I_RST_B)
    $changed(half_clk) |-> $past(I_PLL_OUT) && !$past(I_PLL_OUT, 2))
    else $error("Halved clock changed without a PLL rising edge");
  a_bypass_mux: assert property ( // [R7]
    @(posedge I_CLK) disable iff (!I_RST_B)
    (int_q == `MPCP_INT_BYPASS) |=> mux_q == $past(ref_q) && O_BYPASS)
    else $error("Zero integer factor did not bypass the PLL");
  a_pll_mux: assert property ( // [R6]
    @(posedge I_CLK) disable iff (!I_RST_B)
    (int_q != `MPCP_INT_BYPASS) |=> mux_q == $past(half_clk) && !O_BYPASS)
    else $error("Mux did not select the halved PLL clock");
  a_sys_passes: assert property ( // [R8]
    @(posedge I_CLK) disable iff (!I_RST_B)
    (div_q == `MPCP_DIV_PASS) |=> O_SYS_CLK == $past(mux_q))
    else $error("System clock does not pass the mux output");
  a_sys_divided: assert property ( // [R8]
    @(posedge I_CLK) disable iff (!I_RST_B)
    (div_q != `MPCP_DIV_PASS && $stable(div_q)) |=>
    O_SYS_CLK == $past(sys_div_clk))
    else $error("System clock does not follow its divider");
  a_read_factor: assert property ( // [R3]
    @(posedge I_CLK) disable iff (!I_RST_B)
    (I_RD && I_ADDR == `MPCP_ADDR_FACTOR) |=> O_RDATA[6:0] == $past(int_q))
    else $error("Factor readback wrong");
endmodule : mpcp_top
`default_nettype wire

// ===== dv/mpcp_top_bench.sv
// Self-checking bench for the main clock path block.
`timescale 1ns/1ns
`default_nettype none
`include "mpcp_consts.svh"
module mpcp_top_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  mpcp_pkg::mpcp_addr_t addr = 8'h00;
  mpcp_pkg::mpcp_data_t wdata = 32'h0;
  logic wr = 1'b0, rd = 1'b0, prim = 1'b0, aux = 1'b0, pll = 1'b0;
  mpcp_pkg::mpcp_data_t rdata;
  mpcp_pkg::mpcp_int_t int_f;
  logic [7:0] frac_f;
  logic ref_c, usb_c, can_c, byp, sys_c;
  int mismatches = 0;
  int checks_done = 0;
  logic [16:0] seed = 17'h12437;
  mpcp_top #(.FRAC_W(8)) u_dut (.I_CLK(clk), .I_RST_B(rst_b),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .I_PRIMARY_CLOCK_PIN(prim), .I_AUX_CLOCK_PIN(aux), .I_PLL_OUT(pll),
    .O_RDATA(rdata), .O_PLL_INT_FACTOR(int_f), .O_PLL_FRAC_FACTOR(frac_f),
    .O_PLL_REF_CLK(ref_c), .O_AUX_CLK_USB(usb_c), .O_AUX_CLK_CAN(can_c),
    .O_BYPASS(byp), .O_SYS_CLK(sys_c));
  // A 10 MHz clock; half period of 50 ns.
  always #50 clk = ~clk;
  // Shift register source; a 17-bit width keeps the start value in range.
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg
  // Drives the pins for a window and checks each stage against a model.
  task automatic run(input int n, input int dv);
    logic [31:0] r;
    logic q[$];
    int rises, e, k, m_cnt;
    logic last, pr, ax, pl;
    logic m_ref, m_prv, m_half, m_mux, m_sprv, m_sdiv, m_sys;
    logic [2:0] m_st;
    // A short reset at the start of each run puts design and model in one known state.
    @(posedge clk);
    prim <= 1'b0;
    pll <= 1'b0;
    aux <= 1'b0;
    rst_b <= 1'b0;
    @(posedge clk);
    chk("rst_bypass", byp, 1);
    chk("rst_int", int_f, 0);
    rst_b <= 1'b1;
    rises = 0;
    m_cnt = 0;
    m_st = 3'h0;
    {m_ref, m_prv, m_half, m_mux, m_sprv, m_sdiv, m_sys} = 7'h00;
    wr_reg(`MPCP_ADDR_FACTOR, n);
    wr_reg(`MPCP_ADDR_DIVSEL, dv);
    last = sys_c;
    for (k = 0; k < 112; k++) begin
      @(posedge clk);
      pr = prim;
      ax = aux;
      pl = pll;
      q.push_back(pr);
      // Model stages, latest first, so each reads last cycle's value.
      m_sys = (dv == 0) ? m_mux : m_sdiv;
      if (m_mux && !m_sprv && dv != 0) begin
        m_cnt = m_cnt + 1;
        if (m_cnt >= dv) begin
          m_cnt = 0;
          m_sdiv = !m_sdiv;
        end
      end
      m_sprv = m_mux;
      m_mux = (n == 0) ? m_ref : m_half;
      if (pl && !m_prv) begin
        m_half = !m_half;
      end
      m_prv = pl;
      m_ref = pr;
      // A status read in mid-window sees the stage levels of this cycle.
      if (k == 60) begin
        m_st = {m_sys, m_mux, n == 0};
        addr <= `MPCP_ADDR_STATUS;
        rd <= 1'b1;
      end
      if (k == 61) begin
        rd <= 1'b0;
      end
      seed = lfsr(seed);
      prim <= k[3];
      // A four-cycle period stands for a PLL output kept in range.
      pll <= k[1];
      aux <= seed[0];
      @(negedge clk);
      chk("ref_clk", ref_c, pr);
      chk("aux_usb", usb_c, ax);
      chk("aux_can", can_c, ax);
      chk("sys_model", sys_c, m_sys);
      if (n == 0 && dv == 0 && k > 3) chk("sys_pass", sys_c, q[k-2]);
      if (k == 61) chk("status", rdata, m_st);
      if (k == 62) chk("rdata_idle", rdata, 0);
      if (k >= 16 && sys_c === 1'b1 && last === 1'b0) rises++;
      last = sys_c;
    end
    // Bypass base period is 16 cycles, halved PLL base is 8.
    e = 96 / ((n == 0 ? 16 : 8) * (dv == 0 ? 1 : 2 * dv));
    chk("sys_rises", (rises + 1 >= e && rises <= e + 1), 1);
    chk("bypass", byp, n == 0);
    rd_reg(`MPCP_ADDR_STATUS, r);
    chk("st_bypass", r[`MPCP_ST_BYPASS], n == 0);
    rd_reg(`MPCP_ADDR_DIVSEL, r);
    chk("divsel_rd", r, dv);
    $display("test done: clock path factor %0d divsel %0d", n, dv);
  endtask : run
  // Watchdog sized well beyond the expected run of about 660 cycles.
  initial begin
    #(100 * 5000);
    mismatches++;
    end_of_test();
  end
  initial begin
    logic [31:0] d, r;
    int i;
    repeat (3) @(posedge clk);
    chk("rst_bypass", byp, 1);
    rst_b <= 1'b1;
    rd_reg(`MPCP_ADDR_FACTOR, r);
    chk("rst_factor", r, 0);
    $display("test done: reset");
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      d = {seed[15:0], seed[16:1]};
      if (i == 0) d[6:0] = 7'h00;
      d[6] = 1'b0;
      wr_reg(`MPCP_ADDR_FACTOR, d);
      repeat (2) @(negedge clk);
      chk("int_f", int_f, d[6:0]);
      chk("frac_f", frac_f, d[15:8]);
      chk("bypass", byp, d[6:0] == 0);
      rd_reg(`MPCP_ADDR_FACTOR, r);
      chk("factor_rd", r, {16'h0, d[15:8], 1'b0, d[6:0]});
    end
    rd_reg(8'h0C, r);
    chk("unmapped", r, 0);
    $display("test done: factor register");
    run(0, 0);
    run(5, 0);
    run(5, 1);
    run(0, 2);
    run(9, 3);
    end_of_test();
  end
endmodule : mpcp_top_bench
`default_nettype wire
